// ---- shared/dpsm_regs.vh ----
// Register offsets, field positions, state codes and timing constants
`ifndef DPSM_REGS_VH
`define DPSM_REGS_VH

// ====================
// Register offsets (word index on the register port)
`define DPSM_ADDR_W 4
`define DPSM_OFF_CMD 4'h0
`define DPSM_OFF_STATE 4'h1
`define DPSM_OFF_MODE_SEL 4'h2
`define DPSM_OFF_MODE_ACT 4'h3
`define DPSM_OFF_FAULT 4'h4

// ====================
// Command word field positions
`define DPSM_CMD_SWITCH_ON 0
`define DPSM_CMD_ENABLE_VOLT 1
`define DPSM_CMD_QUICK_STOP_N 2
`define DPSM_CMD_ENABLE_OP 3
`define DPSM_CMD_FAULT_RESET 7

// ====================
// Reset values
`define DPSM_CMD_RESET 16'h0000
`define DPSM_MODE_RESET 8'h00

// ====================
// Status word patterns, bits 6, 5 and 3..0
`define DPSM_SW_NOT_READY 16'h0000
`define DPSM_SW_SO_DISABLED 16'h0040
`define DPSM_SW_READY 16'h0021
`define DPSM_SW_SWITCHED_ON 16'h0023
`define DPSM_SW_OP_ENABLED 16'h0027
`define DPSM_SW_QS_ACTIVE 16'h0007
`define DPSM_SW_FAULT_REACT 16'h000f
`define DPSM_SW_FAULT 16'h0008

// ====================
// Timing: self-test time in ns and derived cycle count at 25 MHz
`define DPSM_CLK_NS 40
`define DPSM_SELFTEST_NS 400
`define DPSM_SELFTEST_CYC (`DPSM_SELFTEST_NS / `DPSM_CLK_NS)
`define DPSM_FAULT_REACT_NS 200
`define DPSM_FAULT_REACT_CYC (`DPSM_FAULT_REACT_NS / `DPSM_CLK_NS)

`endif

// ---- src/dpsm_sync.v ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module dpsm_sync (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Pin in, clean level out
  input wire pin_in,
  output reg level_out
);

  reg stage1;
  reg stage2;
  reg stage3;

  // ====================
  // Sync chain; level follows once stages two and three agree
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level_out <= stage3;
    end
  end

endmodule // dpsm_sync

// ---- src/dpsm_edge.v ----
// Rising edge detector for command word bits
`timescale 1ns/1ps
module dpsm_edge (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Level in, one-cycle pulse out
  input wire level_in,
  output wire rise
);

  reg level_d;

  // ====================
  // Previous level; starts high so a set bit at reset is no edge
  always @(posedge sys_clk)
  begin
    if (rst)
      level_d <= 1'b1;
    else
      level_d <= level_in;
  end

  assign rise = level_in & ~level_d;

endmodule // dpsm_edge

// ---- src/dpsm_top.v ----
// Drive power state machine with command and state words
//
// What this block does
// - State changes come from command word, timer (self-test and fault reaction ends) and fault/fatal pins
// - State word always shows present state
// - Decode shutdown and switch-on commands
// - Decode disable voltage and quick stop
// - Enable operation; switch-on pattern disables operation
// - Fault reset and quick-stop return edge-triggered
// - Encode not-ready, disabled, fault patterns
// - Encode ready, switched, enabled, quick-stop patterns
// - After self-test enter switch on disabled
// - Unrecoverable error locks in not ready
// - Mode selected and mode displayed kept separate
// - Mode selection writable in any state
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "dpsm_regs.vh"
module dpsm_top (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register port
  input wire [`DPSM_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Device events from pins
  input wire fault_pin,
  input wire fatal_pin,
  // Drive status
  output reg [15:0] drive_state_word,
  output reg [7:0] mode_active,
  output reg power_enabled
);

  // ====================
  // One-hot states
  localparam [8:0] ST_SELFTEST = 9'h001;
  localparam [8:0] ST_NOT_READY = 9'h002;
  localparam [8:0] ST_SO_DISABLED = 9'h004;
  localparam [8:0] ST_READY = 9'h008;
  localparam [8:0] ST_SWITCHED_ON = 9'h010;
  localparam [8:0] ST_OP_ENABLED = 9'h020;
  localparam [8:0] ST_QS_ACTIVE = 9'h040;
  localparam [8:0] ST_FAULT_REACT = 9'h080;
  localparam [8:0] ST_FAULT = 9'h100;

  localparam integer SELFTEST_CYC = `DPSM_SELFTEST_CYC;
  localparam integer REACT_CYC = `DPSM_FAULT_REACT_CYC;

  // ====================
  // Declarations
  reg [15:0] drive_command_word;
  reg [7:0] mode_select;
  reg [8:0] state;
  reg [8:0] next_state;
  reg [7:0] timer;
  reg fatal_seen;
  reg fault_seen;
  wire fault_lvl;
  wire fatal_lvl;
  wire fault_reset_rise;
  wire enable_op_rise;

  // ====================
  // Command decode
  // shutdown pattern decode
  function is_shutdown(input [15:0] cw);
    is_shutdown = ~cw[7] & cw[2] & cw[1] & ~cw[0];
  endfunction

  function is_switch_on(input [15:0] cw);
    is_switch_on = ~cw[7] & ~cw[3] & cw[2] & cw[1] & cw[0];
  endfunction

  function is_disable_volt(input [15:0] cw);
    is_disable_volt = ~cw[7] & ~cw[1];
  endfunction

  function is_quick_stop(input [15:0] cw);
    is_quick_stop = ~cw[7] & ~cw[2] & cw[1];
  endfunction

  function is_enable_op(input [15:0] cw);
    is_enable_op = ~cw[7] & cw[3] & cw[2] & cw[1] & cw[0];
  endfunction

  // ====================
  // Pin synchronisers
  dpsm_sync u_sync_fault (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(fault_pin),
    .level_out(fault_lvl)
  );

  dpsm_sync u_sync_fatal (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(fatal_pin),
    .level_out(fatal_lvl)
  );

  // ====================
  // Edge detectors on command bits
  // fault reset edge
  dpsm_edge u_edge_fr (
    .sys_clk(sys_clk),
    .rst(rst),
    .level_in(drive_command_word[`DPSM_CMD_FAULT_RESET]),
    .rise(fault_reset_rise)
  );

  dpsm_edge u_edge_eo (
    .sys_clk(sys_clk),
    .rst(rst),
    .level_in(drive_command_word[`DPSM_CMD_ENABLE_OP]),
    .rise(enable_op_rise)
  );

  // ====================
  // Register writes
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      drive_command_word <= `DPSM_CMD_RESET;
      mode_select <= `DPSM_MODE_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `DPSM_OFF_CMD)
        drive_command_word <= reg_wdata;
      if (reg_addr == `DPSM_OFF_MODE_SEL)
        mode_select <= reg_wdata[7:0];
    end
  end

  // ====================
  // Active mode follows selection
  always @(posedge sys_clk)
  begin
    if (rst)
      mode_active <= `DPSM_MODE_RESET;
    else
      mode_active <= mode_select;
  end

  // ====================
  // Sticky error flags; set wins over clear
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      fatal_seen <= 1'b0;
      fault_seen <= 1'b0;
    end
    else
    begin
      if (fatal_lvl)
        fatal_seen <= 1'b1;
      if (fault_lvl)
        fault_seen <= 1'b1;
      else if (state == ST_FAULT_REACT || state == ST_FAULT)
        fault_seen <= 1'b0; // Cleared once the pin is quiet again
    end
  end

  // ====================
  // Next state logic
  always @*
  begin
    next_state = state;
    case (state)
      ST_SELFTEST:
      begin
        if (timer == SELFTEST_CYC[7:0])
          next_state = ST_SO_DISABLED;
      end
      ST_NOT_READY:
        next_state = ST_NOT_READY;
      ST_SO_DISABLED:
        if (is_shutdown(drive_command_word))
          next_state = ST_READY;
      ST_READY:
      begin
        if (is_disable_volt(drive_command_word) |
            is_quick_stop(drive_command_word))
          next_state = ST_SO_DISABLED;
        else if (is_switch_on(drive_command_word))
          next_state = ST_SWITCHED_ON;
        else if (is_enable_op(drive_command_word))
          next_state = ST_SWITCHED_ON;
      end
      ST_SWITCHED_ON:
      begin
        if (is_disable_volt(drive_command_word) |
            is_quick_stop(drive_command_word))
          next_state = ST_SO_DISABLED;
        else if (is_shutdown(drive_command_word))
          next_state = ST_READY;
        else if (is_enable_op(drive_command_word))
          next_state = ST_OP_ENABLED;
      end
      ST_OP_ENABLED:
      begin
        if (is_disable_volt(drive_command_word))
          next_state = ST_SO_DISABLED;
        else if (is_quick_stop(drive_command_word))
          next_state = ST_QS_ACTIVE;
        else if (is_shutdown(drive_command_word))
          next_state = ST_READY;
        else if (is_switch_on(drive_command_word))
          next_state = ST_SWITCHED_ON;
      end
      ST_QS_ACTIVE:
      begin
        if (is_disable_volt(drive_command_word))
          next_state = ST_SO_DISABLED;
        else if (enable_op_rise & ~drive_command_word[7] &
                 drive_command_word[1] & drive_command_word[0])
          next_state = ST_OP_ENABLED;
      end
      ST_FAULT_REACT:
        if (timer == REACT_CYC[7:0])
          next_state = ST_FAULT;
      ST_FAULT:
      begin
        if (fault_reset_rise)
          next_state = ST_SO_DISABLED;
      end
      default:
        next_state = ST_SELFTEST;
    endcase
    // Error overrides
    if (state != ST_SELFTEST && state != ST_NOT_READY)
    begin
      if (fault_seen && state != ST_FAULT_REACT && state != ST_FAULT)
        next_state = ST_FAULT_REACT;
    end
    if (fatal_seen && state != ST_NOT_READY)
      next_state = ST_NOT_READY;
  end

  // ====================
  // State register and timer
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= ST_SELFTEST;
      timer <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        timer <= 8'h00;
      else if (timer != 8'hff)
        timer <= timer + 8'h01;
    end
  end

  // ====================
  // State word encoding
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      drive_state_word <= `DPSM_SW_NOT_READY;
      power_enabled <= 1'b0;
    end
    else
    begin
      power_enabled <= (next_state == ST_OP_ENABLED) |
                       (next_state == ST_QS_ACTIVE);
      case (next_state)
        ST_SELFTEST: drive_state_word <= `DPSM_SW_NOT_READY;
        ST_NOT_READY: drive_state_word <= `DPSM_SW_NOT_READY;
        ST_SO_DISABLED: drive_state_word <= `DPSM_SW_SO_DISABLED;
        ST_FAULT_REACT: drive_state_word <= `DPSM_SW_FAULT_REACT;
        ST_FAULT: drive_state_word <= `DPSM_SW_FAULT;
        ST_READY: drive_state_word <= `DPSM_SW_READY;
        ST_SWITCHED_ON: drive_state_word <= `DPSM_SW_SWITCHED_ON;
        ST_OP_ENABLED: drive_state_word <= `DPSM_SW_OP_ENABLED;
        ST_QS_ACTIVE: drive_state_word <= `DPSM_SW_QS_ACTIVE;
        default: drive_state_word <= `DPSM_SW_NOT_READY;
      endcase
    end
  end

  // ====================
  // Register reads, data one cycle after strobe
  always @(posedge sys_clk)
  begin
    if (rst | ~reg_rd)
      reg_rdata <= 16'h0000;
    else
    begin
      case (reg_addr)
        `DPSM_OFF_CMD: reg_rdata <= drive_command_word;
        `DPSM_OFF_STATE: reg_rdata <= drive_state_word;
        `DPSM_OFF_MODE_SEL: reg_rdata <= {8'h00, mode_select};
        `DPSM_OFF_MODE_ACT: reg_rdata <= {8'h00, mode_active};
        `DPSM_OFF_FAULT: reg_rdata <= {14'h0000, fatal_seen, fault_seen};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule // dpsm_top

// ---- dv/dpsm_master.sv ----
// Fieldbus master model on the register port
`timescale 1ns/1ps
module dpsm_master (
  // Clock
  input wire sys_clk,
  // Register port
  output reg [3:0] reg_addr = 4'h0,
  output reg [15:0] reg_wdata = 16'h0000,
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  input wire [15:0] reg_rdata
);
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d; // Released lines never hold old data
    end
  endtask

  // Read: data taken in the cycle after the strobe
  task rd(input [3:0] a, output [15:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      // Mid-cycle, while the answer stands
      @(negedge sys_clk);
      d = reg_rdata;
    end
  endtask
endmodule // dpsm_master

// ---- dv/dpsm_top_chk.sv ----
// Port checker for the drive power state machine
`timescale 1ns/1ps
`include "dpsm_regs.vh"
module dpsm_top_chk (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register port
  input wire [`DPSM_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Drive status
  input wire [15:0] drive_state_word,
  input wire [7:0] mode_active,
  input wire power_enabled
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Command word write in this cycle
  wire cmd_wr = reg_wr && reg_addr == 4'h0;
  wire [15:0] sw = drive_state_word;

  // ====================
  // Assertions
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_legal_code: assert property (
    sw inside {16'h0000, 16'h0040, 16'h0021, 16'h0023, 16'h0027,
      16'h0007, 16'h000f, 16'h0008})
    else $error("state word pattern unknown");
  a_power_flag: assert property (
    power_enabled == (sw == 16'h0027 || sw == 16'h0007))
    else $error("power flag wrong");
  a_enable_op: assert property (
    cmd_wr && (reg_wdata & 16'h008f) == 16'h000f && sw == 16'h0023
    |-> ##2 sw == 16'h0027)
    else $error("enable operation missed");
  a_shutdown_cmd: assert property (
    cmd_wr && (reg_wdata & 16'h0087) == 16'h0006
    && sw inside {16'h0040, 16'h0023, 16'h0027} |-> ##2 sw == 16'h0021)
    else $error("shutdown missed");
  a_disable_volt: assert property (
    cmd_wr && (reg_wdata & 16'h0082) == 16'h0000
    && sw inside {16'h0021, 16'h0023, 16'h0027, 16'h0007}
    |-> ##2 sw == 16'h0040)
    else $error("disable voltage missed");
  a_fatal_hold: assert property (
    sw == 16'h0000 && $past(sw) != 16'h0000 |-> ##1 (sw == 16'h0000) [*8])
    else $error("left not ready state");
  a_mode_mirror: assert property (
    reg_wr && reg_addr == 4'h2
    |-> ##2 mode_active == $past(reg_wdata[7:0], 2))
    else $error("mode not shown");
  a_selftest_end: assert property (
    $fell(rst) |-> ##[1:12] sw == 16'h0040)
    else $error("self-test end missed");
endmodule // dpsm_top_chk

bind dpsm_top dpsm_top_chk i_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .drive_state_word(drive_state_word),
  .mode_active(mode_active),
  .power_enabled(power_enabled)
);

// ---- dv/drive_power_state_machine_bench.sv ----
// Self-checking bench for the drive power state machine
`timescale 1ns/1ps
`include "dpsm_regs.vh"
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      mismatches++; \
      $display("BAD %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module drive_power_state_machine_bench;
  // ====================
  // Signals
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg fault_pin = 1'b0;
  reg fatal_pin = 1'b0;
  wire [3:0] reg_addr;
  wire [15:0] reg_wdata;
  wire reg_wr;
  wire reg_rd;
  wire [15:0] reg_rdata;
  wire [15:0] drive_state_word;
  wire [7:0] mode_active;
  wire power_enabled;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int i;
  int n;
  reg seen = 1'b0;
  reg [15:0] rdv;
  reg [15:0] want;
  reg [31:0] rows [0:10];

  dpsm_top i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fault_pin(fault_pin), .fatal_pin(fatal_pin),
    .drive_state_word(drive_state_word), .mode_active(mode_active),
    .power_enabled(power_enabled));
  dpsm_master i_master (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // Clock
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end

  // Closing report
  task test_done;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      mismatches++;
      $display("BAD %0t timeout", $time);
      test_done;
    end
  end

  // State word checked over the bus and at the pins
  task chk_state(input [15:0] w);
    begin
      i_master.rd(4'h1, rdv);
      `CHK(rdv & 16'h006f, w)
      `CHK(drive_state_word & 16'h006f, w)
    end
  endtask

  // Bounded wait for a state, noting fault reaction on the way
  task wait_state(input [15:0] w);
    begin
      for (n = 0; n < 40 && (drive_state_word & 16'h006f) !== w; n++)
      begin
        @(negedge sys_clk);
        if (drive_state_word === 16'h000f)
          seen = 1'b1;
      end
    end
  endtask

  // ====================
  // Main sequence
  initial
  begin
    rows = '{32'h0006_0021, 32'h0007_0023, 32'h000f_0027, 32'h0007_0023,
      32'h000f_0027, 32'h000b_0007, 32'h000f_0007, 32'h0007_0007,
      32'h000f_0027, 32'h000e_0021, 32'h000d_0040};
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK(drive_state_word, 16'h0000)
    repeat (12) @(posedge sys_clk);
    chk_state(16'h0040);
    $display("reset test done");
    // Command rows, with a mode write in every state the rows reach
    for (i = 0; i < 11; i++)
    begin
      want = rows[i][15:0];
      i_master.wr(4'h0, rows[i][31:16]);
      i_master.wr(4'h2, i[15:0]);
      repeat (3) @(posedge sys_clk);
      chk_state(want);
      `CHK(power_enabled, want == 16'h0027 || want == 16'h0007)
      i_master.rd(4'h3, rdv);
      `CHK(rdv, i[15:0])
      `CHK(mode_active, i[7:0])
      i_master.rd(4'h2, rdv);
      `CHK(rdv, i[15:0])
    end
    $display("row tests done");
    // Read-only and unmapped places refuse commands
    i_master.wr(4'h1, 16'h0006);
    i_master.wr(4'hf, 16'h0006);
    repeat (3) @(posedge sys_clk);
    chk_state(16'h0040);
    i_master.rd(4'hf, rdv);
    `CHK(rdv, 16'h0000)
    $display("refusal test done");
    // Fault, steady reset bit, then a real rising edge
    i_master.wr(4'h0, 16'h0080);
    i_master.rd(4'h0, rdv);
    `CHK(rdv, 16'h0080)
    @(posedge sys_clk) fault_pin <= 1'b1;
    wait_state(16'h0008);
    `CHK(seen, 1'b1)
    i_master.rd(4'h4, rdv);
    `CHK(rdv, 16'h0001)
    @(posedge sys_clk) fault_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk_state(16'h0008);
    i_master.wr(4'h0, 16'h0000);
    i_master.wr(4'h0, 16'h0080);
    repeat (3) @(posedge sys_clk);
    chk_state(16'h0040);
    $display("fault test done");
    // Unrecoverable error ignores later commands
    @(posedge sys_clk) fatal_pin <= 1'b1;
    wait_state(16'h0000);
    @(posedge sys_clk) fatal_pin <= 1'b0;
    i_master.wr(4'h0, 16'h0006);
    repeat (5) @(posedge sys_clk);
    chk_state(16'h0000);
    i_master.rd(4'h4, rdv);
    `CHK(rdv, 16'h0002)
    $display("fatal test done");
    test_done;
  end
endmodule // drive_power_state_machine_bench
